//--- include/ahcd_pkg.sv
// constants and types for the converter host control decode
package ahcd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  // internal master clock period when the clock pin is grounded
  localparam int INT_MCLK_NS = 500;
  localparam int INT_MCLK_DIV = (INT_MCLK_NS * 1000) / CLK_PERIOD_PS;
  // no edge on the clock pin for this long means it is grounded
  localparam int MCLK_LOSS_NS = 2000;
  localparam int MCLK_LOSS_CYC = (MCLK_LOSS_NS * 1000) / CLK_PERIOD_PS;
  // extra master clocks per conversion in interleave mode
  localparam int INTERLEAVE_EXTRA_MCLKS = 20;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int RESULT_W = 14;
  localparam int STATUS_W = 8;
  localparam int CNT_W = 16;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AHCD_TRACK = 2'b00,
    AHCD_CONV = 2'b01,
    AHCD_FULLCAL = 2'b10,
    AHCD_BURST = 2'b11
  } ahcd_state_t;

  // host-side control pins, all taken as synchronous to clk_sys
  typedef struct packed {
    logic holdN;
    logic csN;
    logic calReq;
    logic interleaveTuneN;
    logic rdN;
    logic outputSelect;
    logic resetPin;
  } ahcd_pins_t;

endpackage

//--- rtl/ahcd_control_decode.sv
// control decode of a self-calibrating converter behind its host pins
`timescale 1ns/10ps
`default_nettype none

// Operation
// - falling hold edge while tracking, outside reset, holds the input and starts a conversion
// - hold high, select low, calibrate low ends burst calibration, back to tracking
// - data bus floats whenever chip select or read strobe is high
// - select, hold and output-select all low resets the device internally
// - output-select is ignored except for reads and the software reset
// - an external master clock on the clock pin times conversions
// - clock pin grounded means the master clock is generated internally
// - reset pin high clears the sequencer, mode latches and calibration flag, not the clock source or bus; its release starts a full calibration
// - read drives converted data with output-select high, status when low
// - interleave request low at select rise enters interleave mode, high leaves
// - calibrate high at a select edge calibrates continuously and refuses conversions
module ahcd_control_decode
  import ahcd_pkg::*;
#(
  parameter int CONV_MCLKS = 100,
  parameter int FULL_CAL_MCLKS = 1000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ahcd_pins_t pins,
  input wire logic masterClockIn,
  input wire logic [RESULT_W-1:0] convResult,
  input wire logic [STATUS_W-1:0] statusByte,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic convStart,
  output logic endOfConv,
  output logic calActive,
  output logic burstMode,
  output logic interleaveMode,
  output logic useExtClock,
  output logic masterTick
);

  // lengths the cycle counter cannot hold stop elaboration
  if (CONV_MCLKS < 1 || CONV_MCLKS + INTERLEAVE_EXTRA_MCLKS >= 2**CNT_W) begin : g_bad_conv
    $error("CONV_MCLKS out of range");
  end
  if (FULL_CAL_MCLKS < 1 || FULL_CAL_MCLKS >= 2**CNT_W) begin : g_bad_cal
    $error("FULL_CAL_MCLKS out of range");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstSyncB_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSyncB_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncB_r <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // master clock source
  // ----------------------------------------------------------------
  logic mclkPrev_r;
  logic [CNT_W-1:0] lossCnt_r;
  logic [CNT_W-1:0] divCnt_r;
  logic useExt_r;
  logic tick_r;

  wire extEdge = masterClockIn & ~mclkPrev_r;
  wire lossHit = (lossCnt_r == CNT_W'(MCLK_LOSS_CYC - 1));
  wire divHit = (divCnt_r == CNT_W'(INT_MCLK_DIV - 1));
  // falls back to the divider once the pin has gone quiet
  wire extSel = extEdge | (useExt_r & ~lossHit);
  wire tickNxt = extSel ? extEdge : divHit;

  always_ff @(posedge clk_sys or negedge rstSyncB_r) begin
    if (!rstSyncB_r) begin
      mclkPrev_r <= 1'b0;
      lossCnt_r <= CNT_RST;
      divCnt_r <= CNT_RST;
      useExt_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      mclkPrev_r <= masterClockIn;
      lossCnt_r <= (extEdge || lossHit) ? CNT_RST : lossCnt_r + 1'b1;
      divCnt_r <= divHit ? CNT_RST : divCnt_r + 1'b1;
      useExt_r <= extSel;
      tick_r <= tickNxt;
    end
  end

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  logic holdPrev_r;
  logic csPrev_r;
  logic clrPrev_r;

  // output-select only takes part in the reset combination and reads
  wire softReset = ~pins.csN & ~pins.holdN & ~pins.outputSelect;
  wire clrAll = pins.resetPin | softReset;
  wire clrRelease = clrPrev_r & ~clrAll;
  wire holdFall = holdPrev_r & ~pins.holdN & ~clrAll;
  wire csRise = ~csPrev_r & pins.csN;
  wire csFall = csPrev_r & ~pins.csN;
  wire readOn = ~pins.csN & ~pins.rdN;
  wire readStart = readOn & ~dataOe;
  wire burstStop = pins.holdN & ~pins.csN & ~pins.calReq;
  wire burstNxt = burstStop ? 1'b0 : (csRise | csFall) ? pins.calReq : burstMode;
  wire ilvNxt = csRise ? ~pins.interleaveTuneN : interleaveMode;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  ahcd_state_t state_r;
  ahcd_state_t stateNxt;
  logic [CNT_W-1:0] cnt_r;

  wire [CNT_W-1:0] convLen = interleaveMode ?
    CNT_W'(CONV_MCLKS + INTERLEAVE_EXTRA_MCLKS) : CNT_W'(CONV_MCLKS);
  wire convDone = (state_r == AHCD_CONV) && tick_r && (cnt_r == convLen - 1'b1);
  wire calDone = (state_r == AHCD_FULLCAL) && tick_r &&
    (cnt_r == CNT_W'(FULL_CAL_MCLKS - 1));
  // a burst request waits for the running conversion to finish
  wire startConv = (state_r == AHCD_TRACK) && holdFall && !burstMode;

  always_comb begin
    stateNxt = state_r;
    case (state_r)
      AHCD_TRACK: begin
        if (startConv)
          stateNxt = AHCD_CONV;
        else if (burstMode)
          stateNxt = AHCD_BURST;
      end
      AHCD_CONV: begin
        if (convDone)
          stateNxt = AHCD_TRACK;
      end
      AHCD_FULLCAL: begin
        if (calDone)
          stateNxt = AHCD_TRACK;
      end
      AHCD_BURST: begin
        if (!burstMode)
          stateNxt = AHCD_TRACK;
      end
      default: stateNxt = AHCD_TRACK;
    endcase
    if (clrRelease)
      stateNxt = AHCD_FULLCAL;
  end

  wire stateChange = (stateNxt != state_r);
  wire [CNT_W-1:0] cntNxt = stateChange ? CNT_RST : tick_r ? cnt_r + 1'b1 : cnt_r;
  wire eocNxt = (startConv | readStart) ? 1'b1 : (convDone | calDone) ? 1'b0 : endOfConv;
  // status reads need hold high; low hold with output-select low is a reset
  wire [DATA_W-1:0] dataNxt = pins.outputSelect ?
    DATA_W'(convResult) : DATA_W'(statusByte);

  always_ff @(posedge clk_sys or negedge rstSyncB_r) begin
    if (!rstSyncB_r) begin
      holdPrev_r <= 1'b1;
      csPrev_r <= 1'b1;
      clrPrev_r <= 1'b1;
      state_r <= AHCD_TRACK;
      cnt_r <= CNT_RST;
      burstMode <= 1'b0;
      interleaveMode <= 1'b0;
      endOfConv <= 1'b1;
      convStart <= 1'b0;
      dataOe <= 1'b0;
      dataOut <= DATA_RST;
    end else begin
      holdPrev_r <= pins.holdN;
      csPrev_r <= pins.csN;
      clrPrev_r <= clrAll;
      dataOe <= readOn;
      dataOut <= readOn ? dataNxt : DATA_RST;
      if (clrAll) begin
        state_r <= AHCD_TRACK;
        cnt_r <= CNT_RST;
        burstMode <= 1'b0;
        interleaveMode <= 1'b0;
        endOfConv <= 1'b1;
        convStart <= 1'b0;
      end else begin
        state_r <= stateNxt;
        cnt_r <= cntNxt;
        burstMode <= burstNxt;
        interleaveMode <= ilvNxt;
        endOfConv <= eocNxt;
        convStart <= startConv;
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  logic calActive_r;

  // a clear drops the flag at once, not one cycle late
  wire calNxt = !clrAll && (stateNxt == AHCD_FULLCAL || stateNxt == AHCD_BURST);

  always_ff @(posedge clk_sys or negedge rstSyncB_r) begin
    if (!rstSyncB_r) begin
      calActive_r <= 1'b0;
    end else begin
      calActive_r <= calNxt;
    end
  end

  assign calActive = calActive_r;
  assign useExtClock = useExt_r;
  assign masterTick = tick_r;

endmodule // ahcd_control_decode

`default_nettype wire

//--- sim/ahcd_chk_properties.sv
// port assertions for the converter control decode
`timescale 1ns/10ps
`default_nettype none
module ahcd_chk
  import ahcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ahcd_pins_t pins,
  input wire logic dataOe,
  input wire logic convStart,
  input wire logic endOfConv,
  input wire logic calActive,
  input wire logic burstMode,
  input wire logic interleaveMode
);
  logic [1:0] upCnt_r;
  // outputs hold reset values until the third edge after release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
  end
  wire logic clr = pins.resetPin | (!pins.csN & !pins.holdN & !pins.outputSelect);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b || upCnt_r != 2'h3);
  chk_bus_float: assert property ((pins.csN | pins.rdN) |=> !dataOe)
    else $error("bus not floated");
  chk_start_edge: assert property (convStart |-> $past(pins.holdN, 2) && !$past(pins.holdN)
    && endOfConv && !calActive) else $error("bad conversion start");
  chk_burst_refuse: assert property (calActive && burstMode |=> !convStart)
    else $error("conversion during burst");
  chk_burst_latch: assert property ($rose(pins.csN) && pins.calReq && !clr |=> burstMode)
    else $error("burst not latched");
  chk_burst_stop: assert property (pins.holdN && !pins.csN && !pins.calReq |=> !burstMode)
    else $error("burst not stopped");
  chk_ilv_latch: assert property ($rose(pins.csN) && !clr |=>
    interleaveMode == !$past(pins.interleaveTuneN)) else $error("interleave latch");
  chk_clear_all: assert property (clr |=> !burstMode && !interleaveMode && !convStart)
    else $error("clear ignored");
  chk_cal_start: assert property ($fell(clr) |-> ##[1:3] calActive)
    else $error("no calibration after clear");
  cover property (convStart && interleaveMode);
  cover property (calActive && burstMode);
  cover property ($fell(clr));
endmodule // ahcd_chk
bind ahcd_control_decode ahcd_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .pins(pins),
  .dataOe(dataOe), .convStart(convStart), .endOfConv(endOfConv), .calActive(calActive),
  .burstMode(burstMode), .interleaveMode(interleaveMode));
`default_nettype wire

//--- sim/ahcd_mclk_src.sv
// host-side master clock source; off stands for a grounded clock pin
`timescale 1ns/10ps
`default_nettype none
module ahcd_mclk_src (
  input wire logic clk_sys,
  input wire logic en,
  output logic masterClockIn
);
  logic [1:0] div_r = 2'h0;
  // two cycles high, two low: each level lasts more than one sample
  assign masterClockIn = en & div_r[1];
  always_ff @(posedge clk_sys) div_r <= div_r + 2'h1;
endmodule // ahcd_mclk_src
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the converter control decode
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ahcd_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, mclkEn = 1'b1, prevOe = 1'b0;
  ahcd_pins_t pins = 7'h6e;
  logic [RESULT_W-1:0] convResult = 14'h0000;
  logic [STATUS_W-1:0] statusByte = 8'h00;
  logic [DATA_W-1:0] dataOut, expQ[$];
  logic masterClockIn, dataOe, convStart, endOfConv, calActive, burstMode, interleaveMode;
  logic useExtClock, masterTick;
  localparam int CONV_N = 5;
  localparam int CAL_N = 10;
  logic inConv = 1'b0;
  int errCount = 0, nCompared = 0, ticks = 0, starts = 0, nA, nB;
  initial forever #12.5 clk_sys = ~clk_sys;
  ahcd_mclk_src u_src (.clk_sys(clk_sys), .en(mclkEn), .masterClockIn(masterClockIn));
  ahcd_control_decode #(.CONV_MCLKS(CONV_N), .FULL_CAL_MCLKS(CAL_N)) u_dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .pins(pins), .masterClockIn(masterClockIn), .convResult(convResult),
    .statusByte(statusByte), .dataOut(dataOut), .dataOe(dataOe), .convStart(convStart),
    .endOfConv(endOfConv), .calActive(calActive), .burstMode(burstMode),
    .interleaveMode(interleaveMode), .useExtClock(useExtClock), .masterTick(masterTick));
  task automatic chk(input logic [DATA_W-1:0] seen, exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic giveVerdict();
    $display("compared %0d errors %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // pins: holdN csN calReq interleaveTuneN rdN outputSelect resetPin
  task automatic drive(input logic [6:0] v);
    @(posedge clk_sys);
    pins <= v;
  endtask
  // look just after the edge so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic waitLow(input bit eoc);
    int n = 0;
    settle(6);
    while ((eoc ? endOfConv : calActive) !== 1'b0 && n < 3000) begin
      settle(1);
      n++;
    end
    chk(16'(n < 3000), 16'h0001, "busy");
  endtask
  task automatic conv(output int nt);
    nt = ticks;
    drive(7'h2c | {5'h00, 1'($urandom), 1'b0});
    drive(7'h6e);
    waitLow(1'b1);
    nt = ticks - nt;
  endtask
  task automatic rd(input logic os);
    logic [RESULT_W-1:0] r = RESULT_W'($urandom);
    logic [STATUS_W-1:0] s = STATUS_W'($urandom);
    expQ.push_back(os ? {2'b00, r} : {8'h00, s});
    drive(7'h48 | {5'h00, os, 1'b0});
    convResult <= r;
    statusByte <= s;
    settle(1);
    drive(7'h6e);
    settle(2);
    chk(dataOe, 16'h0000, "float");
    chk(endOfConv, 16'h0001, "eocrd");
  endtask
  // count only the master ticks the conversion itself consumes, whatever the phase
  always @(posedge clk_sys) begin
    if (masterTick === 1'b1 && (convStart === 1'b1 || (inConv && endOfConv === 1'b1))) ticks++;
    starts += int'(convStart === 1'b1);
    if (dataOe === 1'b1 && !prevOe) begin
      if (expQ.size() > 0) chk(dataOut, expQ.pop_front(), "rd");
      else chk(dataOe, 16'h0000, "unasked rd");
    end
    prevOe <= (dataOe === 1'b1);
    if (convStart === 1'b1) inConv <= 1'b1;
    else if (endOfConv !== 1'b1) inConv <= 1'b0;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    giveVerdict();
  end
  initial begin
    void'($urandom(32'h0000_e11c));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    waitLow(1'b0);
    chk(useExtClock, 16'h0001, "ext");
    conv(nA);
    chk(16'(nA), 16'(CONV_N), "clen");
    rd(1'b1);
    rd(1'b0);
    drive(7'h46);
    drive(7'h66);
    settle(2);
    chk(interleaveMode, 16'h0001, "ilv");
    conv(nB);
    chk(16'(nB - nA), 16'(INTERLEAVE_EXTRA_MCLKS), "extra");
    drive(7'h0c);
    drive(7'h4e);
    settle(1);
    chk(interleaveMode, 16'h0000, "soft");
    drive(7'h6e);
    settle(3);
    chk(calActive, 16'h0001, "scal");
    waitLow(1'b0);
    drive(7'h5e);
    drive(7'h7e);
    settle(2);
    chk(burstMode, 16'h0001, "burst");
    chk(calActive, 16'h0001, "bcal");
    nB = starts;
    drive(7'h3e);
    drive(7'h7e);
    settle(3);
    chk(16'(starts - nB), 16'h0000, "refuse");
    drive(7'h4e);
    drive(7'h6e);
    settle(0);
    chk(burstMode, 16'h0000, "stop");
    waitLow(1'b0);
    drive(7'h46);
    drive(7'h66);
    drive(7'h6f);
    settle(2);
    chk(interleaveMode, 16'h0000, "rpin");
    chk(calActive, 16'h0000, "rclr");
    drive(7'h6e);
    settle(3);
    chk(calActive, 16'h0001, "rcal");
    waitLow(1'b0);
    mclkEn <= 1'b0;
    settle(120);
    chk(useExtClock, 16'h0000, "int");
    conv(nB);
    chk(16'(nB), 16'(nA), "ticks");
    chk(16'(expQ.size()), 16'h0000, "pending");
    giveVerdict();
  end
endmodule // testbench
`default_nettype wire
